// [priority_controller.v]
// Eight-input vectored priority interrupt controller, top level
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "prio_ctrl_regs.vh"

module priority_controller #(
  parameter NUM_IN = 8,
  parameter LOGN   = 3
) (
  // Clock and reset
  input  wire              SYS_CLK,
  input  wire              RESET_N,
  // Register port
  input  wire              ADDR,
  input  wire [7:0]        WDATA,
  input  wire              WR,
  input  wire              RD,
  output reg  [7:0]        RDATA,
  // Request inputs
  input  wire [NUM_IN-1:0] REQ_IN,
  // Processor handshake
  output reg               INT_REQ,
  input  wire              INT_ACK,
  output reg  [7:0]        VECTOR,
  output reg               VECTOR_VALID
);

  // ============================================================
  // Init sequence states
  localparam ST_IDLE  = 4'b0001;
  localparam ST_WAIT2 = 4'b0010;
  localparam ST_WAIT3 = 4'b0100;
  localparam ST_WAIT4 = 4'b1000;

  // Mode, mask and rotation state; reset clears all but state, single, master and bottom
  reg  [3:0]        state;
  reg               ready;      // Initialisation done
  reg               single;
  reg               edge_mode;
  reg               auto_end;
  reg               master;
  reg               full_nest;
  reg  [4:0]        vec_base;
  reg  [2:0]        slave_id;
  reg  [NUM_IN-1:0] cascade;
  reg  [NUM_IN-1:0] mask;
  reg  [NUM_IN-1:0] in_service;
  reg  [LOGN-1:0]   bottom;
  reg               rot_auto;
  reg               special_mask;
  reg               read_sel;   // 1 selects in-service view
  reg               poll_armed;
  reg  [NUM_IN-1:0] clear_req;

  // Latched requests and the outcome of both resolvers
  wire [NUM_IN-1:0] pending;
  wire              req_found;
  wire [LOGN-1:0]   req_level;
  wire              isr_found;
  wire [LOGN-1:0]   isr_level;

  // ============================================================
  // Request latch and two resolvers (requests, in-service)
  req_capture #(.WIDTH(NUM_IN)) u_cap (
    .clk       (SYS_CLK),
    .reset_n   (RESET_N),
    .edge_mode (edge_mode),
    .clear     (clear_req),
    .lines     (REQ_IN),
    .pending   (pending)
  );

  // Masked inputs stay latched but never compete
  wire [NUM_IN-1:0] live_req = pending & ~mask;

  // Special mask hides masked in-service levels from blocking
  wire [NUM_IN-1:0] block_isr = special_mask ?
                                (in_service & ~mask) : in_service;

  // Both resolvers share one rotation point, so their ranks compare
  prio_resolver #(.WIDTH(NUM_IN), .LOGW(LOGN)) u_req (
    .req    (live_req),
    .bottom (bottom),
    .found  (req_found),
    .level  (req_level)
  );

  prio_resolver #(.WIDTH(NUM_IN), .LOGW(LOGN)) u_isr (
    .req    (block_isr),
    .bottom (bottom),
    .found  (isr_found),
    .level  (isr_level)
  );

  // Rank 0 is top: distance above the bottom, minus one
  wire [LOGN-1:0] req_rank = req_level - bottom - 1'b1;
  wire [LOGN-1:0] isr_rank = isr_level - bottom - 1'b1;

  // Winner must strictly outrank the top level in service; in fully
  // nested mode a cascade input may re-interrupt its own level.
  // The master cannot see a slave's own ranking, so it leaves the
  // host to sort that out through the slave's in-service register.
  wire cas_same = full_nest && cascade[req_level] &&
                  isr_found && (req_level == isr_level);
  wire wins = ready && req_found &&
              (!isr_found || (req_rank < isr_rank) ||
               cas_same);

  // ============================================================
  // Command decoding helpers
  wire       is_init1 = WR && (ADDR == `ADDR_CMD) &&
                        WDATA[`INIT1_FLAG_BIT];
  wire       is_op2   = WR && (ADDR == `ADDR_CMD) && ready &&
                        (WDATA[4:3] == 2'b00);
  wire       is_op3   = WR && (ADDR == `ADDR_CMD) && ready &&
                        (WDATA[4:3] == 2'b01);
  wire [2:0] op2_cmd  = WDATA[7:5];
  wire [LOGN-1:0] op2_lvl = WDATA[LOGN-1:0];
  // Acknowledge and poll only count once initialised
  wire       ack_take = INT_ACK && ready;
  wire       poll_rd  = RD && poll_armed;

  // ============================================================
  // Init sequence, modes and mask register
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state        <= ST_IDLE;
      ready        <= 1'b0;
      single       <= 1'b1;
      edge_mode    <= 1'b0;
      auto_end     <= 1'b0;
      master       <= 1'b1;
      full_nest    <= 1'b0;
      vec_base     <= 5'h00;
      slave_id     <= 3'h0;
      cascade      <= 8'h00;
      mask         <= `RESET_MASK;
      bottom       <= `RESET_BOTTOM;
      rot_auto     <= 1'b0;
      special_mask <= 1'b0;
      read_sel     <= 1'b0;
      poll_armed   <= 1'b0;
    end else begin
      if (poll_rd)
        poll_armed <= 1'b0;
      if (is_init1) begin
        // New init clears modes back to fixed priority
        state        <= ST_WAIT2;
        ready        <= 1'b0;
        single       <= WDATA[`INIT1_SINGLE_BIT];
        edge_mode    <= WDATA[`INIT1_EDGE_BIT];
        mask         <= `RESET_MASK;
        bottom       <= `RESET_BOTTOM;
        rot_auto     <= 1'b0;
        special_mask <= 1'b0;
        read_sel     <= 1'b0;
        poll_armed   <= 1'b0;
      end else if (WR && (ADDR == `ADDR_DATA)) begin
        case (state)
          ST_WAIT2: begin
            vec_base <= WDATA[7:3];
            slave_id <= WDATA[`INIT2_ID_HI:`INIT2_ID_LO];
            state    <= single ? ST_WAIT4 : ST_WAIT3;
          end
          ST_WAIT3: begin
            cascade <= WDATA;
            state   <= ST_WAIT4;
          end
          ST_WAIT4: begin
            auto_end  <= WDATA[`INIT4_AUTO_BIT];
            master    <= WDATA[`INIT4_MASTER_BIT];
            full_nest <= WDATA[`INIT4_FULLNEST_BIT];
            ready     <= 1'b1;
            state     <= ST_IDLE;
          end
          ST_IDLE: begin
            // Data writes before the first init word are dropped
            if (ready)
              mask <= WDATA;
          end
          default: state <= ST_IDLE;
        endcase
      end else if (is_op2) begin
        case (op2_cmd)
          `OP2_ROT_AUTO_SET: rot_auto <= 1'b1;
          `OP2_ROT_AUTO_CLR: rot_auto <= 1'b0;
          // Rotation moves the bottom to the level just finished
          `OP2_ROT_AUTO_END: begin
            rot_auto <= 1'b1;
            if (isr_found)
              bottom <= isr_level;
          end
          `OP2_NONSPEC_END: begin
            if (rot_auto && isr_found)
              bottom <= isr_level;
          end
          `OP2_SET_BOTTOM:   bottom <= op2_lvl;
          `OP2_ROT_SPEC_END: bottom <= op2_lvl;
          default: bottom <= bottom;
        endcase
      end else if (is_op3) begin
        if (WDATA[`OP3_READ_EN_BIT])
          read_sel <= WDATA[`OP3_READ_SEL_BIT];
        if (WDATA[`OP3_SMM_EN_BIT])
          special_mask <= WDATA[`OP3_SMM_SET_BIT];
        // Poll arms for exactly one following read
        poll_armed <= WDATA[`OP3_POLL_BIT];
      end
    end
  end

  // ============================================================
  // In-service register; set on acknowledge unless auto end is on, cleared by end
  reg [NUM_IN-1:0] next_in_service;
  reg [NUM_IN-1:0] take_one;
  always @* begin
    next_in_service = in_service;
    take_one        = {NUM_IN{1'b0}};
    // Ends go first, so a take in the same cycle is not lost
    if (is_op2) begin
      if ((op2_cmd == `OP2_NONSPEC_END ||
           op2_cmd == `OP2_ROT_AUTO_END) && isr_found)
        next_in_service[isr_level] = 1'b0;
      if (op2_cmd == `OP2_SPEC_END || op2_cmd == `OP2_ROT_SPEC_END)
        next_in_service[op2_lvl] = 1'b0;
    end
    if ((ack_take && wins) || (poll_rd && ready && req_found &&
        wins)) begin
      take_one[req_level] = 1'b1;
      if (!auto_end)
        next_in_service = next_in_service | take_one;
    end
    if (is_init1)
      next_in_service = {NUM_IN{1'b0}};
  end

  // Edge latches of the taken input are consumed
  always @* begin
    clear_req = take_one;
  end

  // In-service flops; reset leaves nothing in service
  always @(posedge SYS_CLK) begin
    if (!RESET_N)
      in_service <= {NUM_IN{1'b0}};
    else
      in_service <= next_in_service;
  end

  // ============================================================
  // Outputs: request line, vector, read data (all registered)
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      INT_REQ      <= 1'b0;
      VECTOR       <= 8'h00;
      VECTOR_VALID <= 1'b0;
      RDATA        <= 8'h00;
    end else begin
      // Held low while a poll is armed, since the host polls instead
      INT_REQ      <= wins && !poll_armed && !ack_take;
      VECTOR_VALID <= ack_take && wins;
      if (ack_take && wins) begin
        // A cascaded slave answers with its id; a master or a single-mode controller names its level
        if (!master && !single)
          VECTOR <= {vec_base, slave_id};
        else
          VECTOR <= {vec_base, req_level};
      end
      // A poll answer takes precedence over status reads
      if (poll_rd)
        RDATA <= {(req_found && wins), 4'h0, req_level};
      else if (RD && ADDR == `ADDR_DATA)
        RDATA <= mask;
      else if (RD)
        RDATA <= read_sel ? in_service : pending;
      else
        RDATA <= 8'h00;
    end
  end

endmodule

// [prio_ctrl_regs.vh]
// Command word addresses, field positions and reset values of the controller
`ifndef PRIO_CTRL_REGS_VH
`define PRIO_CTRL_REGS_VH

// ============================================================
// Port addresses (one bit selects command port or data port)
`define ADDR_CMD          1'h0
`define ADDR_DATA         1'h1

// ============================================================
// First init word fields (written to command port, bit 4 set)
`define INIT1_FLAG_BIT    4
`define INIT1_SINGLE_BIT  1
`define INIT1_EDGE_BIT    3

// ============================================================
// Fourth init word fields
`define INIT4_AUTO_BIT    1
`define INIT4_MASTER_BIT  2
`define INIT4_FULLNEST_BIT 4

// ============================================================
// Second init word slave id field
`define INIT2_ID_LO       3
`define INIT2_ID_HI       5

// ============================================================
// Operation word two: bits 4:3 = 00, bits 7:5 command, 2:0 level
`define OP2_NONSPEC_END   3'h1
`define OP2_SPEC_END      3'h3
`define OP2_ROT_AUTO_END  3'h5
`define OP2_ROT_AUTO_SET  3'h4
`define OP2_ROT_AUTO_CLR  3'h0
`define OP2_SET_BOTTOM    3'h6
`define OP2_ROT_SPEC_END  3'h7

// ============================================================
// Operation word three: bits 4:3 = 01
`define OP3_READ_SEL_BIT  0
`define OP3_READ_EN_BIT   1
`define OP3_POLL_BIT      2
`define OP3_SMM_SET_BIT   5
`define OP3_SMM_EN_BIT    6

// ============================================================
// Reset values and the poll answer's valid bit
`define RESET_MASK        8'h00
`define RESET_BOTTOM      3'h7
`define POLL_VALID_BIT    7

`endif

// [prio_resolver.v]
// Rotating priority resolver: picks the highest ranked bit of a request set
`timescale 1ns/1ps

module prio_resolver #(
  parameter WIDTH = 8,
  parameter LOGW  = 3
) (
  // Request set and rotation point
  input  wire [WIDTH-1:0] req,
  input  wire [LOGW-1:0]  bottom,
  // Winner
  output reg              found,
  output reg  [LOGW-1:0]  level
);

  integer       k;
  reg [LOGW-1:0] idx;

  // ============================================================
  // Walk from bottom (wrapping) down to bottom+1; the last set bit seen wins
  always @* begin
    found = 1'b0;
    level = {LOGW{1'b0}};
    idx   = {LOGW{1'b0}};
    for (k = WIDTH; k >= 1; k = k - 1) begin
      idx = bottom + k[LOGW-1:0];
      if (req[idx]) begin
        found = 1'b1;
        level = idx;
      end
    end
  end

endmodule

// [req_capture.v]
// Per-input request capture, level or rising-edge sensitive
`timescale 1ns/1ps

module req_capture #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // Control
  input  wire             edge_mode,
  input  wire [WIDTH-1:0] clear,
  // Request lines and latched result
  input  wire [WIDTH-1:0] lines,
  output reg  [WIDTH-1:0] pending
);

  reg [WIDTH-1:0] last;

  // ============================================================
  // One latch per input; a new edge wins over a clear
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_in
      always @(posedge clk) begin
        if (!reset_n) begin
          last[g]    <= 1'b0;
          pending[g] <= 1'b0;
        end else begin
          last[g] <= lines[g];
          if (edge_mode) begin
            if (lines[g] && !last[g])
              pending[g] <= 1'b1;
            else if (clear[g])
              pending[g] <= 1'b0;
          end else begin
            pending[g] <= lines[g]; // Level mode follows the line
          end
        end
      end
    end
  endgenerate

endmodule

// [prio_ctrl_chk.sv]
// Timing checks on the controller's handshake and read port
`timescale 1ns/1ps
// ============================================================
// Checker
module prio_ctrl_chk (
  // Clock and reset
  input wire       SYS_CLK,
  input wire       RESET_N,
  // Register port
  input wire       RD,
  input wire [7:0] RDATA,
  // Processor handshake
  input wire       INT_REQ,
  input wire       INT_ACK,
  input wire [7:0] VECTOR,
  input wire       VECTOR_VALID
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // Acknowledge taken while the request stands, then the answer
  sequence s_ack;
    INT_ACK && INT_REQ;
  endsequence
  sequence s_answer;
    VECTOR_VALID;
  endsequence

  a_ack_answer: assert property (s_ack |=> s_answer)
    else $error("no vector pulse after a taken acknowledge");
  a_ack_drop: assert property (s_ack |=> !INT_REQ)
    else $error("request still high after acknowledge");
  a_valid_pulse: assert property (VECTOR_VALID |=> !VECTOR_VALID)
    else $error("vector valid longer than one cycle");
  a_valid_cause: assert property (VECTOR_VALID |-> $past(INT_ACK))
    else $error("vector valid without acknowledge");
  // Vector must not drift between acknowledges
  a_vec_hold: assert property (!VECTOR_VALID |-> $stable(VECTOR))
    else $error("vector changed without acknowledge");
  a_rdata_zero: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero outside read answer");
  // Init needs at least three writes, so no request can follow reset at once
  a_quiet_rst: assert property ($rose(RESET_N) |-> !INT_REQ [*3])
    else $error("request raised right after reset");
  a_valid_noreq: assert property (VECTOR_VALID |-> !INT_REQ)
    else $error("request high beside vector pulse");
endmodule

// [host_model.sv]
// Processor side model answering the interrupt request
`timescale 1ns/1ps
// ============================================================
// Acknowledge generator
module host_model (
  // Clock and reset
  input  wire clk,
  input  wire reset_n,
  // Bench controls
  input  wire ints_on,
  input  wire slow,
  // Handshake
  input  wire int_req,
  output reg  int_ack
);
  reg [1:0] wait_cnt;

  // Interrupts off means no acknowledge at all, as polling needs
  always @(posedge clk) begin
    if (!reset_n) begin
      int_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      int_ack <= 1'b0;
      if (ints_on && int_req && !int_ack) begin
        if (!slow || wait_cnt == 2'h3) begin
          int_ack  <= 1'b1;
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end else begin
        wait_cnt <= 2'h0;
      end
    end
  end
endmodule

// [tb.sv]
// Self-checking bench of the priority controller
`timescale 1ns/1ps
// ============================================================
// Bench top
module tb;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        addr = 1'b0;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg  [7:0] req = 8'h00;
  reg        ints_on = 1'b0;
  reg        slow = 1'b0;
  reg  [7:0] got;
  wire [7:0] rdata;
  wire       int_req;
  wire       int_ack;
  wire [7:0] vector;
  wire       vector_valid;
  integer    n_errors = 0;
  integer    num_checks = 0;

  // 20 MHz system clock
  always #25 clk = ~clk;

  priority_controller i_priority_controller (
    .SYS_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .REQ_IN(req),
    .INT_REQ(int_req), .INT_ACK(int_ack), .VECTOR(vector),
    .VECTOR_VALID(vector_valid));

  host_model i_host_model (
    .clk(clk), .reset_n(rst_n), .ints_on(ints_on), .slow(slow),
    .int_req(int_req), .int_ack(int_ack));

  task chk(input string what, input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task wr_b(input a, input [7:0] d);
    begin
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task rd_b(input a, output [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask

  task cmd(input [7:0] d);
    wr_b(1'b0, d);
  endtask

  task isr_chk(input [7:0] exp);
    begin
      cmd(8'h0B);
      rd_b(1'b0, got);
      chk("in_service", got, exp);
    end
  endtask

  task idle_chk;
    begin
      tick(6);
      #1 chk("int_req", {7'h00, int_req}, 8'h00);
    end
  endtask

  // Let the host answer once, bounded wait for the vector
  task take(input [7:0] v);
    integer i;
    begin
      @(posedge clk);
      ints_on <= 1'b1;
      for (i = 0; i < 40 && vector_valid !== 1'b1; i = i + 1) begin
        @(posedge clk);
        #1;
      end
      chk("vector_valid", {7'h00, vector_valid}, 8'h01);
      chk("vector", vector, v);
      @(posedge clk);
      ints_on <= 1'b0;
    end
  endtask

  task boot(input [7:0] w1, input [7:0] w4);
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      req   <= 8'h00;
      tick(2);
      rst_n <= 1'b1;
      wr_b(1'b0, w1);
      wr_b(1'b1, 8'h40);
      if (!w1[1]) wr_b(1'b1, 8'h08);
      wr_b(1'b1, w4);
      wr_b(1'b1, 8'h00);
    end
  endtask

  task s_fixed;
    begin
      boot(8'h13, 8'h1D);
      req <= 8'hA8;
      take(8'h43);
      idle_chk;
      req <= 8'hAA;
      take(8'h41);
      isr_chk(8'h0A);
      req <= 8'hA8;
      cmd(8'h20);
      idle_chk;
      cmd(8'h20);
      take(8'h43);
      req <= 8'h00;
      cmd(8'h20);
      cmd(8'h0A);
      rd_b(1'b0, got);
      chk("pending", got, 8'h00);
      idle_chk;
    end
  endtask

  task s_mask;
    begin
      boot(8'h13, 8'h1D);
      req <= 8'h24;
      take(8'h42);
      wr_b(1'b1, 8'h04);
      rd_b(1'b1, got);
      chk("mask", got, 8'h04);
      idle_chk;
      cmd(8'h68);
      take(8'h45);
      cmd(8'h48);
      wr_b(1'b1, 8'h24);
      cmd(8'h65);
      cmd(8'h62);
      idle_chk;
      wr_b(1'b1, 8'h00);
      take(8'h42);
      cmd(8'h20);
    end
  endtask

  task s_rotate;
    begin
      boot(8'h13, 8'h1D);
      slow <= 1'b1;
      cmd(8'h80);
      req <= 8'h50;
      take(8'h44);
      idle_chk;
      cmd(8'h20);
      take(8'h46);
      cmd(8'hA0);
      take(8'h44);
      cmd(8'h20);
      cmd(8'h00);
      cmd(8'hC5);
      req <= 8'h41;
      take(8'h46);
      cmd(8'hE6);
      take(8'h40);
      req <= 8'h00;
      cmd(8'h20);
      isr_chk(8'h00);
    end
  endtask

  task s_poll;
    begin
      boot(8'h13, 8'h1D);
      cmd(8'h0C);
      req <= 8'h0A;
      idle_chk;
      rd_b(1'b0, got);
      chk("poll", got, 8'h81);
      isr_chk(8'h02);
      cmd(8'h0A);
      rd_b(1'b0, got);
      chk("pending", got, 8'h0A);
    end
  endtask

  // Edge capture with hardware end of service
  task s_edge;
    begin
      boot(8'h1B, 8'h1F);
      req <= 8'h04;
      take(8'h42);
      idle_chk;
      isr_chk(8'h00);
      req <= 8'h00;
      tick(2);
      req <= 8'h04;
      take(8'h42);
    end
  endtask

  task s_nest;
    begin
      boot(8'h11, 8'h1D);
      req <= 8'h08;
      take(8'h43);
      take(8'h43);
      req <= 8'h00;
      cmd(8'h20);
      isr_chk(8'h00);
    end
  endtask

  // Re-init without reset as a slave; vector carries the slave id
  task s_slave;
    begin
      boot(8'h13, 8'h1D);
      cmd(8'h11);
      wr_b(1'b1, 8'h68);
      wr_b(1'b1, 8'h00);
      wr_b(1'b1, 8'h09);
      req <= 8'h10;
      take(8'h6D);
      req <= 8'h00;
      cmd(8'h20);
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Main sequence, uninitialised controller first
  initial begin
    tick(20);
    rst_n <= 1'b1;
    req   <= 8'hFF;
    idle_chk;
    s_fixed;
    s_mask;
    s_rotate;
    s_poll;
    s_edge;
    s_nest;
    s_slave;
    print_verdict;
  end

  // Watchdog well past the expected run length
  initial begin
    #500000;
    n_errors = n_errors + 1;
    print_verdict;
  end
endmodule

bind priority_controller prio_ctrl_chk i_prio_ctrl_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .RD(RD), .RDATA(RDATA),
  .INT_REQ(INT_REQ), .INT_ACK(INT_ACK), .VECTOR(VECTOR),
  .VECTOR_VALID(VECTOR_VALID));
